// file: core/v86id_dispatch.sv
// What this block does
// RULE_01: Exceptions and hardware interrupts are class one
// RULE_02: Maskable interrupts class two only with extension
// RULE_03: Software interrupts are class three
// RULE_04: Privilege field sits at flag bits 12-13
// RULE_05: Extension enabled by control bit zero
// RULE_06: Bitmap of 256 flags routes software interrupts
// RULE_07: Software places only valid gate types
// RULE_08: Conforming or nonzero-privilege target raises fault
// RULE_09: Fault error code is target selector
// RULE_10: Valid gate leaves mode, enters level zero
// RULE_11: Push nine state words on kernel stack
// RULE_12: Clear data and extra selectors after saving
// RULE_13: Null selectors never trap at return
// RULE_14: Clear mode, nested, resume, trap; interrupt flag
// RULE_15: Return reloads flags and selectors from stack
// RULE_16: Mode flag kept when returning above level zero
// RULE_17: Protection fault uses vector thirteen
// RULE_18: Without extension, maskable goes through gate
// RULE_19: Virtual flags live only with extension, low privilege
// RULE_20: Virtual flags at bits 19 and 20
// RULE_21: Fixed push order, selectors zero-extended
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
module v86id_dispatch (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic NMI_PIN,
	input wire logic INTR_PIN,
	output logic V86_ACTIVE,
	output logic HANDLER_START,
	output logic GP_FAULT
);
	typedef struct packed {
		v86id_pkg::v86id_state_t state;
		logic [3:0] slot;
		logic [31:0] flags;
		logic [31:0] frame_flags;
		logic [31:0] sp;
		logic cr4_ext;
		logic [1:0] current_privilege_level;
		logic [7:0] intr_vec;
		v86id_pkg::v86id_gate_t gate_type;
		logic gate_conf;
		logic [1:0] gate_dpl;
		logic [15:0] gate_sel;
		logic [31:0] handler;
		logic [15:0] stack0;
		logic [31:0] sp0;
		logic [7:0][31:0] ctx;
		logic [7:0][31:0] redir;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic rd_pend;
		logic [7:0] rd_addr;
		logic [31:0] rdata;
		logic hready;
		logic hresp;
		logic [7:0] ev_vec;
		v86id_pkg::v86id_kind_t ev_kind;
		logic ev_pend;
		logic ret_pend;
		logic [2:0] nmi_sync;
		logic [2:0] intr_sync;
		logic nmi_lvl;
		logic intr_lvl;
		logic nmi_pend;
		logic intr_pend;
		logic [1:0] cls;
		logic route_prog;
		logic fault;
		logic task_gate;
		logic refused;
		logic [7:0] cur_vec;
		logic [15:0] err_code;
		logic start_pulse;
		logic gp_pulse;
	} v86id_core_t;

	localparam v86id_core_t RESET_STATE = '{
		state: v86id_pkg::ST_IDLE,
		gate_type: v86id_pkg::GATE_TRAP32,
		ev_kind: v86id_pkg::KIND_EXC,
		hready: 1'b1,
		hresp: v86id_pkg::HRESP_OKAY,
		default: '0
	};

	v86id_core_t q;
	v86id_core_t d;
	v86id_frame_if fr ();

	logic accept;
	logic take;
	logic [7:0] t_vec;
	v86id_pkg::v86id_kind_t t_kind;
	logic [31:0] word;

	v86id_frame_store u_frame (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.fr(fr)
	);

	// Virtual interrupt flags exist only with the extension on and privilege field below max
	function automatic logic virq_active(input logic [31:0] flags, input logic ext);
		virq_active = ext && (flags[v86id_pkg::IO_PRIVILEGE_FIELD_MSB:v86id_pkg::IO_PRIVILEGE_FIELD_LSB] != v86id_pkg::IO_PRIVILEGE_FIELD_MAX); // RULE_19 RULE_04
	endfunction : virq_active

	// Frame slot to context word; slot six holds the flag image
	function automatic logic [2:0] slot_ctx(input logic [3:0] s);
		slot_ctx = (s < v86id_pkg::SLOT_FLAGS) ? 3'(v86id_pkg::CTX_EXTRA_G - s[2:0])
			: 3'(v86id_pkg::SLOT_LAST - s);
	endfunction : slot_ctx

	function automatic logic is_selector(input logic [2:0] idx);
		is_selector = (idx != v86id_pkg::CTX_IP) && (idx != v86id_pkg::CTX_SP);
	endfunction : is_selector

	function automatic logic [31:0] status_word(input v86id_core_t s);
		status_word = v86id_pkg::ZERO_WORD;
		status_word[1:0] = s.cls;
		status_word[v86id_pkg::ST_BUSY_BIT] = (s.state != v86id_pkg::ST_IDLE);
		status_word[v86id_pkg::ST_ROUTE_BIT] = s.route_prog;
		status_word[v86id_pkg::ST_FAULT_BIT] = s.fault;
		status_word[v86id_pkg::ST_TASK_BIT] = s.task_gate;
		status_word[v86id_pkg::ST_REFUSED_BIT] = s.refused;
		status_word[v86id_pkg::ST_VEC_LSB +: 8] = s.cur_vec;
		status_word[v86id_pkg::ST_ERR_LSB +: 16] = s.err_code;
	endfunction : status_word

	function automatic logic [31:0] reg_read(input v86id_core_t s, input logic [7:0] a);
		reg_read = v86id_pkg::ZERO_WORD;
		if (a[7:5] == v86id_pkg::PAGE_CTX) begin
			reg_read = s.ctx[a[4:2]];
		end else if (a[7:5] == v86id_pkg::PAGE_REDIR) begin
			reg_read = s.redir[a[4:2]];
		end else begin
			case (a)
				v86id_pkg::ADDR_FLAGS: begin
					reg_read = s.flags;
					if (!virq_active(s.flags, s.cr4_ext)) begin
						reg_read[v86id_pkg::FLAG_VIRQ_EN] = 1'b0; // RULE_20
						reg_read[v86id_pkg::FLAG_VIRQ_PEND] = 1'b0; // RULE_20
					end
				end
				v86id_pkg::ADDR_CTRL4: reg_read[v86id_pkg::CR4_EXT_BIT] = s.cr4_ext;
				v86id_pkg::ADDR_PRIV: reg_read[1:0] = s.current_privilege_level;
				v86id_pkg::ADDR_EVENT: reg_read = {20'(0), s.ret_pend, s.ev_pend, s.ev_kind, s.ev_vec};
				v86id_pkg::ADDR_GATE: reg_read = {s.gate_sel, 11'(0), s.gate_dpl, s.gate_conf, s.gate_type};
				v86id_pkg::ADDR_HANDLER: reg_read = s.handler;
				v86id_pkg::ADDR_STACK0: reg_read[15:0] = s.stack0;
				v86id_pkg::ADDR_SP0: reg_read = s.sp0;
				v86id_pkg::ADDR_STATUS: reg_read = status_word(s);
				v86id_pkg::ADDR_INTR_VEC: reg_read[7:0] = s.intr_vec;
				default: reg_read = v86id_pkg::ZERO_WORD;
			endcase
		end
	endfunction : reg_read

	assign accept = HSEL && HREADY && (HTRANS == v86id_pkg::HTRANS_NONSEQ)
		&& (HSIZE == v86id_pkg::HSIZE_WORD);

	always_comb begin
		d = q;
		take = 1'b0;
		t_vec = q.ev_vec;
		t_kind = q.ev_kind;
		word = fr.rd_data;
		fr.wr_en = 1'b0;
		fr.index = q.slot;
		fr.wr_data = v86id_pkg::ZERO_WORD;
		d.start_pulse = 1'b0;
		d.gp_pulse = 1'b0;
		d.nmi_sync = {q.nmi_sync[1:0], NMI_PIN};
		d.intr_sync = {q.intr_sync[1:0], INTR_PIN};
		if (q.nmi_sync[1] == q.nmi_sync[2]) begin
			d.nmi_lvl = q.nmi_sync[2];
		end
		if (q.intr_sync[1] == q.intr_sync[2]) begin
			d.intr_lvl = q.intr_sync[2];
		end

		// Reads take one wait state so a write just before is already visible
		d.wr_pend = 1'b0;
		d.rd_pend = 1'b0;
		d.hready = 1'b1;
		if (q.rd_pend) begin
			d.rdata = reg_read(q, q.rd_addr);
		end
		if (accept) begin
			if (HWRITE) begin
				d.wr_pend = 1'b1;
				d.wr_addr = HADDR[7:0];
			end else begin
				d.rd_pend = 1'b1;
				d.rd_addr = HADDR[7:0];
				d.hready = 1'b0;
			end
		end
		if (q.wr_pend) begin
			if (q.wr_addr[7:5] == v86id_pkg::PAGE_CTX) begin
				d.ctx[q.wr_addr[4:2]] = is_selector(q.wr_addr[4:2]) ? (HWDATA & v86id_pkg::SEL_MASK)
					: HWDATA;
			end else if (q.wr_addr[7:5] == v86id_pkg::PAGE_REDIR) begin
				d.redir[q.wr_addr[4:2]] = HWDATA;
			end else begin
				case (q.wr_addr)
					v86id_pkg::ADDR_FLAGS: begin
						d.flags = HWDATA;
						if (!virq_active(q.flags, q.cr4_ext)) begin
							d.flags[v86id_pkg::FLAG_VIRQ_EN] = q.flags[v86id_pkg::FLAG_VIRQ_EN]; // RULE_19
							d.flags[v86id_pkg::FLAG_VIRQ_PEND] = q.flags[v86id_pkg::FLAG_VIRQ_PEND]; // RULE_19
						end
					end
					v86id_pkg::ADDR_CTRL4: d.cr4_ext = HWDATA[v86id_pkg::CR4_EXT_BIT]; // RULE_05
					v86id_pkg::ADDR_PRIV: d.current_privilege_level = HWDATA[1:0];
					v86id_pkg::ADDR_GATE: begin
						d.gate_type = v86id_pkg::v86id_gate_t'(HWDATA[1:0]);
						d.gate_conf = HWDATA[v86id_pkg::GATE_CONF_BIT];
						d.gate_dpl = HWDATA[v86id_pkg::GATE_DPL_LSB +: 2];
						d.gate_sel = HWDATA[v86id_pkg::GATE_SEL_LSB +: 16];
					end
					v86id_pkg::ADDR_HANDLER: d.handler = HWDATA;
					v86id_pkg::ADDR_STACK0: d.stack0 = HWDATA[15:0];
					v86id_pkg::ADDR_SP0: d.sp0 = HWDATA;
					v86id_pkg::ADDR_INTR_VEC: d.intr_vec = HWDATA[7:0];
					v86id_pkg::ADDR_STATUS: begin
						// Write one to clear; hardware sets below win in the same cycle
						if (HWDATA[v86id_pkg::ST_ROUTE_BIT]) d.route_prog = 1'b0;
						if (HWDATA[v86id_pkg::ST_FAULT_BIT]) d.fault = 1'b0;
						if (HWDATA[v86id_pkg::ST_TASK_BIT]) d.task_gate = 1'b0;
						if (HWDATA[v86id_pkg::ST_REFUSED_BIT]) d.refused = 1'b0;
					end
					default: d.wr_addr = q.wr_addr;
				endcase
			end
		end

		unique case (q.state)
			v86id_pkg::ST_IDLE: begin
				if (q.ret_pend) begin
					d.ret_pend = 1'b0;
					d.slot = v86id_pkg::SLOT_LAST;
					d.state = v86id_pkg::ST_POP;
				end else if (q.nmi_pend) begin
					take = 1'b1;
					t_vec = v86id_pkg::NMI_VECTOR;
					t_kind = v86id_pkg::KIND_HWI;
					d.nmi_pend = 1'b0;
				end else if (q.intr_pend && q.flags[v86id_pkg::FLAG_INT_EN]) begin
					take = 1'b1;
					t_vec = q.intr_vec;
					t_kind = v86id_pkg::KIND_MASK;
					d.intr_pend = 1'b0;
				end else if (q.ev_pend) begin
					take = 1'b1;
					d.ev_pend = 1'b0;
				end
				if (take) begin
					d.cur_vec = t_vec;
					d.err_code = 16'h0000;
					d.cls = v86id_pkg::CLASS_NONE;
					if (!q.flags[v86id_pkg::FLAG_V86]) begin
						d.refused = 1'b1;
					end else begin
						unique case (t_kind)
							v86id_pkg::KIND_EXC, v86id_pkg::KIND_HWI: begin
								d.cls = v86id_pkg::CLASS_ONE; // RULE_01
								d.state = v86id_pkg::ST_CHECK;
							end
							v86id_pkg::KIND_MASK: begin
								d.cls = q.cr4_ext ? v86id_pkg::CLASS_TWO : v86id_pkg::CLASS_ONE; // RULE_02
								d.state = v86id_pkg::ST_CHECK; // RULE_18
							end
							v86id_pkg::KIND_SOFT: begin
								d.cls = v86id_pkg::CLASS_THREE; // RULE_03
								if (q.cr4_ext && !q.redir[t_vec[7:5]][t_vec[4:0]]) begin
									d.route_prog = 1'b1; // RULE_06
								end else if (q.flags[v86id_pkg::IO_PRIVILEGE_FIELD_MSB:v86id_pkg::IO_PRIVILEGE_FIELD_LSB]
									!= v86id_pkg::IO_PRIVILEGE_FIELD_MAX) begin
									d.cur_vec = v86id_pkg::GP_VECTOR; // RULE_04 RULE_17
									d.gp_pulse = 1'b1;
									d.state = v86id_pkg::ST_CHECK;
								end else begin
									d.state = v86id_pkg::ST_CHECK;
								end
							end
						endcase
					end
				end
			end
			v86id_pkg::ST_CHECK: begin
				d.state = v86id_pkg::ST_IDLE;
				if (q.gate_type == v86id_pkg::GATE_TASK) begin
					d.task_gate = 1'b1;
				end else if (q.gate_type == v86id_pkg::GATE_BAD || q.gate_conf
					|| q.gate_dpl != v86id_pkg::PRIV_KERNEL) begin
					d.fault = 1'b1; // RULE_08 RULE_07
					d.err_code = q.gate_sel; // RULE_09
					d.cur_vec = v86id_pkg::GP_VECTOR; // RULE_17
					d.gp_pulse = 1'b1;
				end else begin
					// Flag image keeps the mode bit set so the return can restore it
					d.frame_flags = q.flags;
					d.flags[v86id_pkg::FLAG_V86] = 1'b0; // RULE_10
					d.current_privilege_level = v86id_pkg::PRIV_KERNEL; // RULE_10
					d.sp = q.sp0;
					d.slot = v86id_pkg::SLOT_FIRST;
					d.state = v86id_pkg::ST_PUSH;
				end
			end
			v86id_pkg::ST_PUSH: begin
				fr.wr_en = 1'b1; // RULE_11
				fr.wr_data = (q.slot == v86id_pkg::SLOT_FLAGS) ? q.frame_flags
					: q.ctx[slot_ctx(q.slot)]; // RULE_21
				d.sp = q.sp - v86id_pkg::WORD_STEP;
				if (q.slot == v86id_pkg::SLOT_LAST) begin
					d.state = v86id_pkg::ST_CLEAR;
				end else begin
					d.slot = q.slot + v86id_pkg::SLOT_ONE;
				end
			end
			v86id_pkg::ST_CLEAR: begin
				d.ctx[v86id_pkg::CTX_DATA] = v86id_pkg::ZERO_WORD; // RULE_12
				d.ctx[v86id_pkg::CTX_EXTRA] = v86id_pkg::ZERO_WORD; // RULE_12
				d.ctx[v86id_pkg::CTX_EXTRA_F] = v86id_pkg::ZERO_WORD; // RULE_12
				d.ctx[v86id_pkg::CTX_EXTRA_G] = v86id_pkg::ZERO_WORD; // RULE_12
				d.ctx[v86id_pkg::CTX_SP] = q.sp;
				d.ctx[v86id_pkg::CTX_STK] = {16'h0000, q.stack0};
				d.ctx[v86id_pkg::CTX_CODE] = {16'h0000, q.gate_sel};
				d.ctx[v86id_pkg::CTX_IP] = q.handler;
				d.flags[v86id_pkg::FLAG_NESTED] = 1'b0; // RULE_14
				d.flags[v86id_pkg::FLAG_RESUME] = 1'b0; // RULE_14
				d.flags[v86id_pkg::FLAG_TRAP] = 1'b0; // RULE_14
				if (q.gate_type == v86id_pkg::GATE_INT32) begin
					d.flags[v86id_pkg::FLAG_INT_EN] = 1'b0; // RULE_14
				end
				d.start_pulse = 1'b1;
				d.state = v86id_pkg::ST_IDLE;
			end
			v86id_pkg::ST_POP: begin
				// No null check on restored selectors, so cleared ones never trap
				if (q.slot == v86id_pkg::SLOT_FLAGS) begin
					d.frame_flags = word; // RULE_15
				end else begin
					d.ctx[slot_ctx(q.slot)] = is_selector(slot_ctx(q.slot))
						? (word & v86id_pkg::SEL_MASK) : word; // RULE_15 RULE_13
				end
				if (q.slot == v86id_pkg::SLOT_FIRST) begin
					d.state = v86id_pkg::ST_RESTORE;
				end else begin
					d.slot = q.slot - v86id_pkg::SLOT_ONE;
				end
			end
			v86id_pkg::ST_RESTORE: begin
				d.flags = q.frame_flags; // RULE_15
				if (q.current_privilege_level != v86id_pkg::PRIV_KERNEL) begin
					d.flags[v86id_pkg::FLAG_V86] = q.flags[v86id_pkg::FLAG_V86]; // RULE_16
				end
				d.current_privilege_level = d.flags[v86id_pkg::FLAG_V86] ? v86id_pkg::PRIV_USER
					: q.ctx[v86id_pkg::CTX_CODE][1:0];
				d.state = v86id_pkg::ST_IDLE;
			end
			default: d.state = v86id_pkg::ST_IDLE;
		endcase

		// Arrivals after the take logic so a slot freed this cycle is reused; a non-return event write while another event is still pending is dropped
		if (q.wr_pend && q.wr_addr == v86id_pkg::ADDR_EVENT) begin
			if (HWDATA[v86id_pkg::EV_RETURN_BIT]) begin
				d.ret_pend = 1'b1;
			end else if (!d.ev_pend) begin
				d.ev_vec = HWDATA[v86id_pkg::EV_VEC_LSB +: 8];
				d.ev_kind = v86id_pkg::v86id_kind_t'(HWDATA[v86id_pkg::EV_KIND_LSB +: 2]);
				d.ev_pend = 1'b1;
			end
		end
		if (q.nmi_sync[1] == q.nmi_sync[2] && q.nmi_sync[2] && !q.nmi_lvl) begin
			d.nmi_pend = 1'b1;
		end
		if (q.intr_sync[1] == q.intr_sync[2] && q.intr_sync[2] && !q.intr_lvl) begin
			d.intr_pend = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			q <= RESET_STATE;
		end else begin
			q <= d;
		end
	end

	assign HRDATA = q.rdata;
	assign HREADYOUT = q.hready;
	assign HRESP = q.hresp;
	assign V86_ACTIVE = q.flags[v86id_pkg::FLAG_V86];
	assign HANDLER_START = q.start_pulse;
	assign GP_FAULT = q.gp_pulse;
endmodule : v86id_dispatch

// file: core/v86id_frame_if.sv
`timescale 1ns/1ns
interface v86id_frame_if;
	logic wr_en;
	logic [v86id_pkg::SLOT_W-1:0] index;
	logic [31:0] wr_data;
	logic [31:0] rd_data;
	modport ctrl (output wr_en, output index, output wr_data, input rd_data);
	modport store (input wr_en, input index, input wr_data, output rd_data);
endinterface : v86id_frame_if

// file: core/v86id_frame_store.sv
`timescale 1ns/1ns
module v86id_frame_store (
	input wire logic clk,
	input wire logic rst_n,
	v86id_frame_if.store fr
);
	typedef struct packed {
		logic [v86id_pkg::FRAME_SLOTS-1:0][31:0] slot;
	} v86id_store_t;

	v86id_store_t q;
	v86id_store_t d;

	always_comb begin
		d = q;
		if (fr.wr_en && (fr.index < v86id_pkg::FRAME_SLOTS)) begin
			d.slot[fr.index] = fr.wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Out-of-range slots read as zero rather than aliasing
	assign fr.rd_data = (fr.index < v86id_pkg::FRAME_SLOTS) ? q.slot[fr.index]
		: v86id_pkg::ZERO_WORD;
endmodule : v86id_frame_store

// file: core/v86id_pkg.sv
package v86id_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] ADDR_FLAGS = 8'h00;
	localparam logic [7:0] ADDR_CTRL4 = 8'h04;
	localparam logic [7:0] ADDR_PRIV = 8'h08;
	localparam logic [7:0] ADDR_EVENT = 8'h0c;
	localparam logic [7:0] ADDR_GATE = 8'h10;
	localparam logic [7:0] ADDR_HANDLER = 8'h14;
	localparam logic [7:0] ADDR_STACK0 = 8'h18;
	localparam logic [7:0] ADDR_SP0 = 8'h1c;
	localparam logic [7:0] ADDR_STATUS = 8'h60;
	localparam logic [7:0] ADDR_INTR_VEC = 8'h64;
	// Context words sit at 0x20..0x3c, redirection bitmap words at 0x40..0x5c
	localparam logic [2:0] PAGE_CTX = 3'h1;
	localparam logic [2:0] PAGE_REDIR = 3'h2;

	// Flag word bit positions
	localparam int FLAG_TRAP = 8;
	localparam int FLAG_INT_EN = 9;
	localparam int IO_PRIVILEGE_FIELD_LSB = 12;
	localparam int IO_PRIVILEGE_FIELD_MSB = 13;
	localparam int FLAG_NESTED = 14;
	localparam int FLAG_RESUME = 16;
	localparam int FLAG_V86 = 17;
	localparam int FLAG_VIRQ_EN = 19;
	localparam int FLAG_VIRQ_PEND = 20;
	localparam int CR4_EXT_BIT = 0;

	localparam logic [1:0] PRIV_KERNEL = 2'h0;
	localparam logic [1:0] PRIV_USER = 2'h3;
	localparam logic [1:0] IO_PRIVILEGE_FIELD_MAX = 2'h3;
	localparam logic [7:0] GP_VECTOR = 8'h0d;
	localparam logic [7:0] NMI_VECTOR = 8'h02;

	// Event word: vector, kind, return request
	localparam int EV_VEC_LSB = 0;
	localparam int EV_KIND_LSB = 8;
	localparam int EV_RETURN_BIT = 16;
	// Gate word: type, conforming, target privilege, target selector
	localparam int GATE_CONF_BIT = 2;
	localparam int GATE_DPL_LSB = 3;
	localparam int GATE_SEL_LSB = 16;
	// Status word
	localparam int ST_BUSY_BIT = 2;
	localparam int ST_ROUTE_BIT = 3;
	localparam int ST_FAULT_BIT = 4;
	localparam int ST_TASK_BIT = 5;
	localparam int ST_REFUSED_BIT = 6;
	localparam int ST_VEC_LSB = 8;
	localparam int ST_ERR_LSB = 16;

	localparam logic [1:0] CLASS_NONE = 2'h0;
	localparam logic [1:0] CLASS_ONE = 2'h1;
	localparam logic [1:0] CLASS_TWO = 2'h2;
	localparam logic [1:0] CLASS_THREE = 2'h3;

	// Frame store
	localparam int FRAME_SLOTS = 9;
	localparam int SLOT_W = 4;
	localparam logic [3:0] SLOT_FIRST = 4'h0;
	localparam logic [3:0] SLOT_FLAGS = 4'h6;
	localparam logic [3:0] SLOT_LAST = 4'h8;
	localparam logic [3:0] SLOT_ONE = 4'h1;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam logic [31:0] SEL_MASK = 32'h0000_ffff;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	// Context word indices
	localparam logic [2:0] CTX_IP = 3'h0;
	localparam logic [2:0] CTX_CODE = 3'h1;
	localparam logic [2:0] CTX_SP = 3'h2;
	localparam logic [2:0] CTX_STK = 3'h3;
	localparam logic [2:0] CTX_EXTRA = 3'h4;
	localparam logic [2:0] CTX_DATA = 3'h5;
	localparam logic [2:0] CTX_EXTRA_F = 3'h6;
	localparam logic [2:0] CTX_EXTRA_G = 3'h7;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		GATE_TRAP32 = 2'h0,
		GATE_INT32 = 2'h1,
		GATE_TASK = 2'h2,
		GATE_BAD = 2'h3
	} v86id_gate_t;

	typedef enum logic [1:0] {
		KIND_EXC = 2'h0,
		KIND_HWI = 2'h1,
		KIND_MASK = 2'h2,
		KIND_SOFT = 2'h3
	} v86id_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CHECK = 3'h1,
		ST_PUSH = 3'h3,
		ST_CLEAR = 3'h2,
		ST_POP = 3'h6,
		ST_RESTORE = 3'h7
	} v86id_state_t;

endpackage : v86id_pkg

// file: verification/test_v86_interrupt_dispatch.sv
`timescale 1ns/1ns
module test_v86_interrupt_dispatch;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = v86id_pkg::HSIZE_WORD;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic hreadyout, hresp, v86_active, handler_start, prot_fault, nmi, intr;
	logic fire_nmi = 1'b0;
	logic fire_intr = 1'b0;
	int bad_count = 0;
	int checks = 0;
	int cycles = 0;
	int starts = 0;
	int faults = 0;

	always #5 clk_sys = ~clk_sys;

	v86id_dispatch dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .NMI_PIN(nmi), .INTR_PIN(intr),
		.V86_ACTIVE(v86_active), .HANDLER_START(handler_start), .GP_FAULT(prot_fault));
	v86id_pin_source src_u (.clk(clk_sys), .fire_nmi(fire_nmi), .fire_intr(fire_intr),
		.nmi(nmi), .intr(intr));

	always @(posedge clk_sys) begin
		cycles++;
		starts += int'(handler_start === 1'b1);
		faults += int'(prot_fault === 1'b1);
		if (cycles == 20000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Ready is read at the falling edge, so it is the value the next rising edge samples
	task automatic await_ready(output logic [31:0] q);
		logic rdy;
		do begin
			@(negedge clk_sys);
			rdy = hreadyout;
			q = hrdata;
			@(posedge clk_sys);
		end while (rdy !== 1'b1);
	endtask : await_ready

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= v86id_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		await_ready(q);
		htrans <= 2'h0;
		hwdata <= d;
		await_ready(q);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0000_0000, q);
	endtask : rd

	task automatic settle();
		logic [31:0] q;
		int n = 0;
		do begin
			rd(v86id_pkg::ADDR_STATUS, q);
			n++;
		end while (q[v86id_pkg::ST_BUSY_BIT] !== 1'b0 && n < 20);
		check(32'(q[v86id_pkg::ST_BUSY_BIT]), 32'h0000_0000);
	endtask : settle

	task automatic s_regs();
		logic [31:0] q;
		wr(v86id_pkg::ADDR_FLAGS, 32'h0018_1000);
		rd(v86id_pkg::ADDR_FLAGS, q);
		check(q, 32'h0000_1000);
		wr(v86id_pkg::ADDR_CTRL4, 32'h0000_0001);
		wr(v86id_pkg::ADDR_FLAGS, 32'h0018_1000);
		rd(v86id_pkg::ADDR_FLAGS, q);
		check(q, 32'h0018_1000);
		wr(v86id_pkg::ADDR_CTRL4, 32'h0000_0000);
		rd(v86id_pkg::ADDR_FLAGS, q);
		check(q, 32'h0000_1000);
		// The write is gated by the privilege field already held, not the one written
		wr(v86id_pkg::ADDR_CTRL4, 32'h0000_0001);
		wr(v86id_pkg::ADDR_FLAGS, 32'h0000_3000);
		wr(v86id_pkg::ADDR_FLAGS, 32'h0018_3000);
		rd(v86id_pkg::ADDR_FLAGS, q);
		check(q, 32'h0000_3000);
		wr(v86id_pkg::ADDR_FLAGS, 32'h0000_1000);
		rd(v86id_pkg::ADDR_FLAGS, q);
		check(q, 32'h0000_1000);
		wr(v86id_pkg::ADDR_CTRL4, 32'h0000_0000);
		wr(8'h80, 32'hffff_ffff);
		rd(8'h80, q);
		check(q, 32'h0000_0000);
	endtask : s_regs

	task automatic s_entry();
		logic [31:0] q;
		int n;
		wr(v86id_pkg::ADDR_GATE, 32'h0008_0001);
		wr(v86id_pkg::ADDR_HANDLER, 32'h0000_4000);
		wr(v86id_pkg::ADDR_SP0, 32'h0000_1000);
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 8; i++) wr(8'h20 + 8'(4 * i), 32'h0000_0a00 + 32'(i));
			wr(v86id_pkg::ADDR_FLAGS, 32'h0003_4300);
			n = starts;
			wr(v86id_pkg::ADDR_EVENT, 32'h0000_0021);
			settle();
			check(32'(starts - n), 32'h0000_0001);
			check(32'(v86_active), 32'h0000_0000);
			rd(v86id_pkg::ADDR_FLAGS, q);
			check(q, 32'h0000_0000);
			for (int i = 4; i < 8; i++) begin
				rd(8'h20 + 8'(4 * i), q);
				check(q, 32'h0000_0000);
			end
			rd(8'h20, q);
			check(q, 32'h0000_4000);
			rd(8'h28, q);
			check(q, 32'h0000_0fdc);
			wr(v86id_pkg::ADDR_PRIV, 32'(j * 3));
			wr(v86id_pkg::ADDR_EVENT, 32'h0001_0000);
			settle();
			check(32'(v86_active), 32'(1 - j));
			rd(8'h34, q);
			check(q, 32'h0000_0a05);
		end
	endtask : s_entry

	task automatic s_fault();
		logic [31:0] g [2] = '{32'h1234_0004, 32'h1238_0008};
		logic [31:0] q;
		int n;
		for (int i = 0; i < 2; i++) begin
			wr(v86id_pkg::ADDR_GATE, g[i]);
			wr(v86id_pkg::ADDR_FLAGS, 32'h0002_0000);
			n = faults;
			wr(v86id_pkg::ADDR_EVENT, 32'h0000_0006);
			settle();
			check(32'(faults - n), 32'h0000_0001);
			rd(v86id_pkg::ADDR_STATUS, q);
			check(q & 32'hffff_ff10, {g[i][31:16], 16'h0d10});
			wr(v86id_pkg::ADDR_STATUS, 32'h0000_0078);
		end
		// Task gate only flags itself; an event outside the mode is refused
		wr(v86id_pkg::ADDR_GATE, 32'h0008_0002);
		for (int i = 0; i < 2; i++) begin
			wr(v86id_pkg::ADDR_STATUS, 32'h0000_0078);
			wr(v86id_pkg::ADDR_FLAGS, i == 0 ? 32'h0002_0000 : 32'h0000_0000);
			wr(v86id_pkg::ADDR_EVENT, 32'h0000_0006);
			settle();
			rd(v86id_pkg::ADDR_STATUS, q);
			check(q & 32'h0000_0070, i == 0 ? 32'h0000_0020 : 32'h0000_0040);
		end
	endtask : s_fault

	task automatic s_classes();
		logic [31:0] ev [6] = '{32'h0122, 32'h0222, 32'h0222, 32'h0345, 32'h0345, 32'h0345};
		logic [31:0] ex [6] = '{32'h2201, 32'h2201, 32'h2202, 32'h450b, 32'h4503, 32'h0d03};
		logic [31:0] q;
		wr(v86id_pkg::ADDR_GATE, 32'h0008_0001);
		for (int i = 0; i < 6; i++) begin
			wr(v86id_pkg::ADDR_CTRL4, 32'(i > 1));
			wr(8'h48, i > 3 ? 32'h0000_0020 : 32'h0000_0000);
			wr(v86id_pkg::ADDR_FLAGS, (i == 3 || i == 4) ? 32'h0002_3000 : 32'h0002_0000);
			wr(v86id_pkg::ADDR_STATUS, 32'h0000_0078);
			wr(v86id_pkg::ADDR_EVENT, ev[i]);
			settle();
			rd(v86id_pkg::ADDR_STATUS, q);
			check(q & 32'h0000_ff0b, ex[i]);
		end
		wr(v86id_pkg::ADDR_CTRL4, 32'h0000_0000);
	endtask : s_classes

	task automatic s_pin(input logic is_nmi, input logic [31:0] exp);
		logic [31:0] q;
		int n = starts;
		wr(v86id_pkg::ADDR_FLAGS, 32'h0002_0200);
		fire_nmi <= is_nmi;
		fire_intr <= !is_nmi;
		@(posedge clk_sys);
		fire_nmi <= 1'b0;
		fire_intr <= 1'b0;
		for (int k = 0; k < 40 && starts == n; k++) @(posedge clk_sys);
		check(32'(starts - n), 32'h0000_0001);
		rd(v86id_pkg::ADDR_STATUS, q);
		check(q & 32'h0000_ff03, exp);
	endtask : s_pin

	initial begin
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		s_regs();
		s_entry();
		s_fault();
		s_classes();
		wr(v86id_pkg::ADDR_INTR_VEC, 32'h0000_0030);
		s_pin(1'b1, 32'h0000_0201);
		s_pin(1'b0, 32'h0000_3001);
		conclude();
	end
endmodule : test_v86_interrupt_dispatch

bind v86id_dispatch v86id_checker chk_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .V86_ACTIVE(V86_ACTIVE),
	.HANDLER_START(HANDLER_START), .GP_FAULT(GP_FAULT));

// file: verification/v86id_assertions.sv
`timescale 1ns/1ns
module v86id_checker (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic V86_ACTIVE,
	input wire logic HANDLER_START,
	input wire logic GP_FAULT
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	wire logic take = HSEL && HREADY && HTRANS == v86id_pkg::HTRANS_NONSEQ
		&& HSIZE == v86id_pkg::HSIZE_WORD;

	a_resp_okay: assert property (HRESP == v86id_pkg::HRESP_OKAY)
		else $error("bus response not okay");
	a_write_nowait: assert property (take && HWRITE |=> HREADYOUT)
		else $error("write data phase stalled");
	a_read_one_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read data phase not one wait");
	// Read data may only move at the end of a stalled read
	a_rdata_hold: assert property ($past(HREADYOUT) |-> $stable(HRDATA))
		else $error("read data moved without a read");
	a_start_pulse: assert property (HANDLER_START |=> !HANDLER_START)
		else $error("handler start longer than one cycle");
	a_fault_pulse: assert property (GP_FAULT |=> !GP_FAULT)
		else $error("fault pulse longer than one cycle");
	a_start_left_mode: assert property (HANDLER_START |-> !V86_ACTIVE)
		else $error("handler started while still in mode");
	a_fault_no_start: assert property (GP_FAULT |-> !HANDLER_START)
		else $error("handler started on a faulting gate");
endmodule : v86id_checker

// file: verification/v86id_pin_source.sv
`timescale 1ns/1ns
module v86id_pin_source (
	input wire logic clk,
	input wire logic fire_nmi,
	input wire logic fire_intr,
	output logic nmi,
	output logic intr
);
	// Held high long enough to pass the filtered synchroniser
	logic [2:0] nmi_cnt = 3'h0;
	logic [2:0] intr_cnt = 3'h0;
	always_ff @(posedge clk) begin
		nmi_cnt <= fire_nmi ? 3'h6 : nmi_cnt - 3'(nmi_cnt != 3'h0);
		intr_cnt <= fire_intr ? 3'h6 : intr_cnt - 3'(intr_cnt != 3'h0);
	end
	assign nmi = nmi_cnt != 3'h0;
	assign intr = intr_cnt != 3'h0;
endmodule : v86id_pin_source
